// ---- verilog/ldi_pkg.sv ----
`default_nettype none
package ldi_pkg;
  // ----------------------------------------------------------------
  // bus and register map (register index, byte address is index * 4)
  // ----------------------------------------------------------------
  localparam int          LDI_AXI_AW      = 12;
  localparam int          LDI_DW          = 16;
  localparam int          LDI_IDX_LSB     = 2;
  localparam logic [7:0]  LDI_IDX_INPIN   = 8'h3A;
  localparam logic [7:0]  LDI_IDX_LDTYPE  = 8'h3B;
  localparam logic [7:0]  LDI_IDX_LDDLY   = 8'h3C;
  localparam logic [7:0]  LDI_IDX_RSV61   = 8'h3D;
  localparam logic [7:0]  LDI_IDX_DBLBUF  = 8'h3E;
  localparam logic [7:0]  LDI_IDX_STATUS  = 8'h80;
  localparam logic [1:0]  LDI_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  LDI_RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] LDI_RST_INPIN   = 16'h8001;
  localparam logic [15:0] LDI_RST_LDTYPE  = 16'h0001;
  localparam logic [15:0] LDI_RST_LDDLY   = 16'h03E8;
  localparam logic [15:0] LDI_RST_RSV61   = 16'h00A8;
  localparam logic [15:0] LDI_RST_DBLBUF  = 16'h00AF;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          LDI_IGN_BIT     = 15;
  localparam int          LDI_HYST_BIT    = 14;
  localparam int          LDI_LVL_HI      = 13;
  localparam int          LDI_LVL_LO      = 12;
  localparam int          LDI_FMT_HI      = 11;
  localparam int          LDI_FMT_LO      = 9;
  localparam int          LDI_FMT_ALIGN   = 0;
  localparam int          LDI_FMT_REQ     = 1;
  localparam int          LDI_FMT_FILT    = 2;
  localparam int          LDI_TYPE_BIT    = 0;
  localparam logic [1:0]  LDI_LVL_INVALID = 2'h3;
  // status register bits
  localparam int          LDI_ST_LOCK     = 0;
  localparam int          LDI_ST_CALLOCK  = 1;
  localparam int          LDI_ST_VTUNE    = 2;
  localparam int          LDI_ST_ALIGN    = 3;
  localparam int          LDI_ST_REQ      = 4;
  localparam int          LDI_ST_CALBUSY  = 5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          LDI_QUARTER_DIV = 4;
  typedef enum logic [1:0] {LDI_S_CAL, LDI_S_COUNT, LDI_S_LOCKED} ldi_lock_state_t;
endpackage
`default_nettype wire

// ---- verilog/ldi_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldi_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // asynchronous in, synchronous out
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/ldi_tick_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module ldi_tick_div #(
  parameter int DIV = 4
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // restart aligns the divider with a new calibration
  input  wire logic restart,
  input  wire logic tick_in,
  output logic      tick_out
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_r;
  wire           wrap = tick_in && (cnt_r == LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      cnt_r    <= '0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= wrap;
      if (tick_in) begin
        cnt_r <= wrap ? '0 : cnt_r + CW'(1);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/ldi_lock_detect_input_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - ignore bit set and alignment mode off: both input pins have no effect.
// - bit 14 enables high hysteresis on both differential receivers.
// - bias code 0 quarter, 1 full, 2 half; code 3 never written.
// - format field sets each pin CMOS or differential, codes 5-7 add filtering.
// - type 0: lock high after calibration done and delay counter expired.
// - type 1: additionally requires tuning voltage inside its window.
// - lock type bit 0 resets to 1, the combined mode.
// - delay counts quarter detector periods after calibration; resets to 03E8h.
module ldi_lock_detect_input_cfg #(
  parameter int AW      = ldi_pkg::LDI_AXI_AW,
  parameter int QDIV    = ldi_pkg::LDI_QUARTER_DIV
) (
  // clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // axi4-lite write address
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read address
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  // axi4-lite read data
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // external input pins (asynchronous)
  input  wire logic          phase_alignment_pin,
  input  wire logic          reference_pulse_request_pin,
  // synthesizer core (same clock)
  input  wire logic          phase_alignment_mode,
  input  wire logic          oscillator_calibration_busy,
  input  wire logic          pd_tick,
  // tuning voltage window comparator (asynchronous)
  input  wire logic          vtune_in_window,
  // gated pin levels toward the alignment and reference logic
  output logic               phase_alignment_level,
  output logic               reference_request_level,
  // receiver configuration
  output logic               receiver_high_hysteresis,
  output logic [1:0]         receiver_bias_level,
  output logic               align_pin_differential,
  output logic               request_pin_differential,
  output logic               input_filter_enable,
  // lock indicator
  output logic               lock_indicator
);
  import ldi_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0]     inpin_r;
  logic [15:0]     ldtype_r;
  logic [15:0]     lddly_r;
  logic [15:0]     rsv61_r;
  logic [15:0]     dblbuf_r;
  logic            aw_full_r;
  logic            w_full_r;
  logic [7:0]      wr_idx_r;
  logic [31:0]     wdata_r;
  logic [3:0]      wstrb_r;
  logic            bvalid_r;
  logic [1:0]      bresp_r;
  logic            rvalid_r;
  logic [31:0]     rdata_r;
  logic [1:0]      rresp_r;
  ldi_lock_state_t state_r;
  ldi_lock_state_t state_nxt;
  logic [15:0]     cnt_r;
  logic            lock_r;
  logic            cal_busy_d_r;
  logic            align_prev_r;
  logic            req_prev_r;
  logic            align_filt_r;
  logic            req_filt_r;

  // ----------------------------------------------------------------
  // pin synchronisers and quarter detector tick
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       qtick;
  wire        cal_start = oscillator_calibration_busy && !cal_busy_d_r;

  ldi_sync2 #(.WIDTH(3)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({vtune_in_window, reference_pulse_request_pin, phase_alignment_pin}),
    .sync_out (pins_s)
  );

  ldi_tick_div #(.DIV(QDIV)) u_qdiv (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .restart  (cal_start),
    .tick_in  (pd_tick),
    .tick_out (qtick)
  );

  wire align_s  = pins_s[0];
  wire req_s    = pins_s[1];
  wire vtune_ok = pins_s[2];

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  // address and data are taken in either order; the response holds both off
  wire        wr_do     = aw_full_r && w_full_r && !bvalid_r;
  wire        wr_inpin  = wr_idx_r == LDI_IDX_INPIN;
  wire        wr_ldtype = wr_idx_r == LDI_IDX_LDTYPE;
  wire        wr_lddly  = wr_idx_r == LDI_IDX_LDDLY;
  wire        wr_rsv61  = wr_idx_r == LDI_IDX_RSV61;
  wire        wr_dblbuf = wr_idx_r == LDI_IDX_DBLBUF;
  wire        wr_hit    = wr_inpin || wr_ldtype || wr_lddly || wr_rsv61 || wr_dblbuf;

  assign s_axi_awready = !aw_full_r && !bvalid_r;
  assign s_axi_wready  = !w_full_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  function automatic logic [15:0] ldi_merge(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
    logic [15:0] m;
    m       = old;
    if (s[0]) begin
      m[7:0] = d[7:0];
    end
    if (s[1]) begin
      m[15:8] = d[15:8];
    end
    return m;
  endfunction

  // a bias code of 3 is refused and the previous code kept
  wire [15:0] inpin_m   = ldi_merge(inpin_r, wdata_r, wstrb_r);
  wire        lvl_bad   = inpin_m[LDI_LVL_HI:LDI_LVL_LO] == LDI_LVL_INVALID;
  wire [15:0] inpin_new = lvl_bad ?
                          {inpin_m[15:LDI_LVL_HI+1], inpin_r[LDI_LVL_HI:LDI_LVL_LO],
                           inpin_m[LDI_LVL_LO-1:0]} : inpin_m;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      wr_idx_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= LDI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        wr_idx_r  <= s_axi_awaddr[LDI_IDX_LSB +: 8];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? LDI_RESP_OKAY : LDI_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // reserved fields are stored as written; keeping them legal is software's job
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inpin_r  <= LDI_RST_INPIN;
      ldtype_r <= LDI_RST_LDTYPE;
      lddly_r  <= LDI_RST_LDDLY;
      rsv61_r  <= LDI_RST_RSV61;
      dblbuf_r <= LDI_RST_DBLBUF;
    end else if (wr_do) begin
      if (wr_inpin) begin
        inpin_r <= inpin_new;
      end
      if (wr_ldtype) begin
        ldtype_r <= ldi_merge(ldtype_r, wdata_r, wstrb_r);
      end
      if (wr_lddly) begin
        lddly_r <= ldi_merge(lddly_r, wdata_r, wstrb_r);
      end
      if (wr_rsv61) begin
        rsv61_r <= ldi_merge(rsv61_r, wdata_r, wstrb_r);
      end
      if (wr_dblbuf) begin
        dblbuf_r <= ldi_merge(dblbuf_r, wdata_r, wstrb_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire [7:0]  rd_idx = s_axi_araddr[LDI_IDX_LSB +: 8];
  wire [15:0] status = {10'h000, oscillator_calibration_busy, req_s, align_s, vtune_ok,
                        state_r == LDI_S_LOCKED, lock_r};
  wire        rd_hit = (rd_idx == LDI_IDX_INPIN) || (rd_idx == LDI_IDX_LDTYPE) ||
                       (rd_idx == LDI_IDX_LDDLY) || (rd_idx == LDI_IDX_RSV61) ||
                       (rd_idx == LDI_IDX_DBLBUF) || (rd_idx == LDI_IDX_STATUS);
  wire [15:0] rd_val = (rd_idx == LDI_IDX_INPIN)  ? inpin_r  :
                       (rd_idx == LDI_IDX_LDTYPE) ? ldtype_r :
                       (rd_idx == LDI_IDX_LDDLY)  ? lddly_r  :
                       (rd_idx == LDI_IDX_RSV61)  ? rsv61_r  :
                       (rd_idx == LDI_IDX_DBLBUF) ? dblbuf_r :
                       (rd_idx == LDI_IDX_STATUS) ? status   : 16'h0000;

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= LDI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {16'h0000, rd_val};
      rresp_r  <= rd_hit ? LDI_RESP_OKAY : LDI_RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // input pin configuration and gating
  // ----------------------------------------------------------------
  wire [2:0] fmt         = inpin_r[LDI_FMT_HI:LDI_FMT_LO];
  wire       pins_ignore = inpin_r[LDI_IGN_BIT] && !phase_alignment_mode;

  assign receiver_high_hysteresis = inpin_r[LDI_HYST_BIT];
  assign receiver_bias_level      = inpin_r[LDI_LVL_HI:LDI_LVL_LO];
  assign align_pin_differential   = fmt[LDI_FMT_ALIGN];
  assign request_pin_differential = fmt[LDI_FMT_REQ];
  assign input_filter_enable      = fmt[LDI_FMT_FILT] && (fmt[LDI_FMT_REQ:LDI_FMT_ALIGN] != 2'h0);

  // filter: a level passes only after two equal samples, rejecting one-cycle glitches
  wire align_use = (input_filter_enable && fmt[LDI_FMT_ALIGN]) ? align_filt_r : align_s;
  wire req_use   = (input_filter_enable && fmt[LDI_FMT_REQ]) ? req_filt_r : req_s;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      align_prev_r            <= 1'b0;
      req_prev_r              <= 1'b0;
      align_filt_r            <= 1'b0;
      req_filt_r              <= 1'b0;
      phase_alignment_level   <= 1'b0;
      reference_request_level <= 1'b0;
    end else begin
      align_prev_r <= align_s;
      req_prev_r   <= req_s;
      if (align_prev_r == align_s) begin
        align_filt_r <= align_s;
      end
      if (req_prev_r == req_s) begin
        req_filt_r <= req_s;
      end
      phase_alignment_level   <= align_use && !pins_ignore;
      reference_request_level <= req_use && !pins_ignore;
    end
  end

  // ----------------------------------------------------------------
  // lock indicator
  // ----------------------------------------------------------------
  wire lock_type = ldtype_r[LDI_TYPE_BIT];
  wire cal_lock  = state_r == LDI_S_LOCKED;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      LDI_S_CAL: begin
        if (!oscillator_calibration_busy) begin
          state_nxt = LDI_S_COUNT;
        end
      end
      LDI_S_COUNT: begin
        if (oscillator_calibration_busy) begin
          state_nxt = LDI_S_CAL;
        end else if (cnt_r == lddly_r) begin
          state_nxt = LDI_S_LOCKED;
        end
      end
      LDI_S_LOCKED: begin
        if (oscillator_calibration_busy) begin
          state_nxt = LDI_S_CAL;
        end
      end
      default: begin
        state_nxt = LDI_S_CAL;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r      <= LDI_S_CAL;
      cnt_r        <= 16'h0000;
      cal_busy_d_r <= 1'b0;
      lock_r       <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      cal_busy_d_r <= oscillator_calibration_busy;
      // a calibration that begins mid-count wins over a coincident quarter tick
      if (oscillator_calibration_busy || state_r == LDI_S_CAL) begin
        cnt_r <= 16'h0000;
      end else if (state_r == LDI_S_COUNT && qtick && cnt_r != lddly_r) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      lock_r <= cal_lock && (!lock_type || vtune_ok);
    end
  end

  assign lock_indicator = lock_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ignore;
    $past(pins_ignore) |-> !phase_alignment_level && !reference_request_level;
  endproperty
  a_ignore: assert property (p_ignore) else $error("input pin passed while ignored");

  property p_hyst;
    wr_do && wr_inpin && wstrb_r[1] |=> receiver_high_hysteresis == $past(wdata_r[LDI_HYST_BIT]);
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis not taken from write");

  property p_bias;
    receiver_bias_level != LDI_LVL_INVALID;
  endproperty
  a_bias: assert property (p_bias) else $error("invalid bias code applied");

  property p_fmt;
    fmt == 3'h4 |-> !align_pin_differential && !request_pin_differential && !input_filter_enable;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format code 4 not both cmos");

  property p_lock_cal;
    lock_indicator |-> $past(state_r) == LDI_S_LOCKED;
  endproperty
  a_lock_cal: assert property (p_lock_cal) else $error("lock without finished delay");

  property p_lock_vt;
    lock_indicator && $past(lock_type) |-> $past(vtune_ok);
  endproperty
  a_lock_vt: assert property (p_lock_vt) else $error("lock outside tuning window");

  property p_rst_type;
    disable iff (1'b0) !aresetn |=> ldtype_r == LDI_RST_LDTYPE;
  endproperty
  a_rst_type: assert property (p_rst_type) else $error("lock type reset wrong");

  property p_dly;
    state_r == LDI_S_COUNT && state_nxt == LDI_S_LOCKED |-> cnt_r == lddly_r;
  endproperty
  a_dly: assert property (p_dly) else $error("delay count mismatch at lock");

  property p_cal_low;
    oscillator_calibration_busy |-> ##2 !lock_indicator;
  endproperty
  a_cal_low: assert property (p_cal_low) else $error("lock high during calibration");

  property p_restart;
    cal_start |=> cnt_r == 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("delay not restarted");
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ldi_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and design ports
  // ----------------------------------------------------------------
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, receiver_bias_level;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        phase_alignment_pin, reference_pulse_request_pin, phase_alignment_mode;
  logic        oscillator_calibration_busy, pd_tick, vtune_in_window;
  logic        phase_alignment_level, reference_request_level, receiver_high_hysteresis;
  logic        align_pin_differential, request_pin_differential, input_filter_enable;
  logic        lock_indicator;
  int          err_count = 0;
  int          n_tests = 0;

  always #10 aclk = ~aclk;
  // phase-detector tick every other cycle, so one quarter tick per 8 cycles
  always @(posedge aclk) pd_tick <= ~pd_tick;

  ldi_lock_detect_input_cfg u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .phase_alignment_pin, .reference_pulse_request_pin, .phase_alignment_mode,
    .oscillator_calibration_busy, .pd_tick, .vtune_in_window,
    .phase_alignment_level, .reference_request_level, .receiver_high_hysteresis,
    .receiver_bias_level, .align_pin_differential, .request_pin_differential,
    .input_filter_enable, .lock_indicator
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // register bus master: ready is looked at on the falling edge, where
  // it equals its value at the next rising edge, to avoid races
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic ap;
    logic wp;
    logic ta;
    logic tw;
    ap = 1'h1;
    wp = 1'h1;
    s_axi_awaddr  <= {2'h0, idx, 2'h0};
    s_axi_wdata   <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (ap || wp) begin
      @(negedge aclk);
      ta = ap && (s_axi_awready === 1'h1);
      tw = wp && (s_axi_wready === 1'h1);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      ap = ap && !ta;
      wp = wp && !tw;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
    chk(s_axi_bresp, er);
    // bready stays high between writes so that no call assigns it twice in one step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr  <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(negedge aclk); while (s_axi_arready !== 1'h1);
    @(posedge aclk);
    s_axi_arvalid <= 1'h0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask

  task automatic do_reset;
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
  endtask

  // calibration of ten cycles; the indicator is checked low once, at its end
  task automatic run_cal;
    oscillator_calibration_busy <= 1'h1;
    repeat (10) @(negedge aclk);
    chk(lock_indicator, 32'h0);
    @(posedge aclk);
    oscillator_calibration_busy <= 1'h0;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (6000) @(posedge aclk);
    err_count++;
    test_done;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] f;
    logic [1:0] l;
    int         n;
    s_axi_awaddr = 12'h000; s_axi_araddr = 12'h000; s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF; s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0; s_axi_arvalid = 1'h0; s_axi_rready = 1'h0;
    phase_alignment_pin = 1'h0; reference_pulse_request_pin = 1'h0;
    phase_alignment_mode = 1'h0; oscillator_calibration_busy = 1'h0;
    pd_tick = 1'h0; vtune_in_window = 1'h0;
    do_reset;
    axi_rd(LDI_IDX_INPIN, 32'h8001, LDI_RESP_OKAY);
    axi_rd(LDI_IDX_LDTYPE, 32'h0001, LDI_RESP_OKAY);
    axi_rd(LDI_IDX_LDDLY, 32'h03E8, LDI_RESP_OKAY);
    axi_rd(LDI_IDX_RSV61, 32'h00A8, LDI_RESP_OKAY);
    axi_rd(LDI_IDX_DBLBUF, 32'h00AF, LDI_RESP_OKAY);
    axi_rd(8'h40, 32'h0, LDI_RESP_SLVERR);
    // every format code, with bias codes 0..2 only, ignore kept set
    for (int i = 0; i < 8; i++) begin
      f = 3'(i);
      l = 2'(i % 3);
      axi_wr(LDI_IDX_INPIN, {1'h1, f[0], l, f, 9'h001}, LDI_RESP_OKAY);
      chk(receiver_high_hysteresis, f[0]);
      chk(receiver_bias_level, l);
      chk({align_pin_differential, request_pin_differential, input_filter_enable},
          {f[0], f[1], f[2] & (f[1:0] != 2'h0)});
    end
    // input gate: ignored while alignment mode off, passed when on
    phase_alignment_pin <= 1'h1;
    reference_pulse_request_pin <= 1'h1;
    repeat (8) @(posedge aclk);
    chk({phase_alignment_level, reference_request_level}, 32'h0);
    phase_alignment_mode <= 1'h1;
    repeat (8) @(posedge aclk);
    chk({phase_alignment_level, reference_request_level}, 32'h3);
    // a one-cycle dip on a filtered pin must never reach the gated level
    phase_alignment_pin <= 1'h0;
    @(posedge aclk);
    phase_alignment_pin <= 1'h1;
    repeat (5) begin
      @(negedge aclk);
      chk(phase_alignment_level, 32'h1);
    end
    @(posedge aclk);
    phase_alignment_mode <= 1'h0;
    repeat (8) @(posedge aclk);
    chk({phase_alignment_level, reference_request_level}, 32'h0);
    // calibration-only lock with the tuning voltage out of window
    axi_wr(LDI_IDX_LDTYPE, 16'h0000, LDI_RESP_OKAY);
    axi_wr(LDI_IDX_LDDLY, 16'h0003, LDI_RESP_OKAY);
    for (int k = 0; k < 2; k++) begin
      run_cal;
      repeat (12) @(negedge aclk);
      chk(lock_indicator, 32'h0);
      for (n = 0; n < 80 && lock_indicator !== 1'h1; n++) @(negedge aclk);
      chk(lock_indicator, 32'h1);
      @(posedge aclk);
    end
    // combined lock needs the tuning voltage too
    axi_wr(LDI_IDX_LDTYPE, 16'h0001, LDI_RESP_OKAY);
    run_cal;
    repeat (60) @(negedge aclk);
    chk(lock_indicator, 32'h0);
    @(posedge aclk);
    vtune_in_window <= 1'h1;
    repeat (6) @(negedge aclk);
    chk(lock_indicator, 32'h1);
    @(posedge aclk);
    vtune_in_window <= 1'h0;
    repeat (6) @(negedge aclk);
    chk(lock_indicator, 32'h0);
    // the reserved register is rewritten with its reset value 00A8h; a second reset restores the type register
    @(posedge aclk);
    axi_wr(LDI_IDX_RSV61, 16'h00A8, LDI_RESP_OKAY);
    axi_rd(LDI_IDX_RSV61, 32'h00A8, LDI_RESP_OKAY);
    axi_wr(LDI_IDX_LDTYPE, 16'h0000, LDI_RESP_OKAY);
    do_reset;
    axi_rd(LDI_IDX_RSV61, 32'h00A8, LDI_RESP_OKAY);
    axi_rd(LDI_IDX_LDTYPE, 32'h0001, LDI_RESP_OKAY);
    test_done;
  end
endmodule
`default_nettype wire
